// file: shared/reset_watchdog_pkg.sv
`default_nettype none

package reset_watchdog_pkg;

    // System clock rate
    localparam int unsigned SYS_CLK_MHZ = 125;

    // Crystal time base
    localparam int unsigned XTAL_HZ = 32768;

    // Longest refresh interval, in milliseconds
    localparam int unsigned DOG_TIMEOUT_MS = 1500;
    localparam int unsigned DOG_TICKS = DOG_TIMEOUT_MS * XTAL_HZ / 1000;
    localparam logic [15:0] DOG_LAST = 16'(DOG_TICKS - 1);

    // Restart delay after a watchdog reset, in crystal cycles
    localparam int unsigned RESTART_TICKS = 4100;
    localparam logic [12:0] RESTART_LAST = 13'(RESTART_TICKS - 1);

    // Longest gap between crystal edges before the oscillator counts as slow
    localparam int unsigned XTAL_GAP_NS = 30518;
    localparam int unsigned XTAL_GAP_CYC = XTAL_GAP_NS * SYS_CLK_MHZ / 1000;
    localparam logic [11:0] XTAL_GAP_LIMIT = 12'(XTAL_GAP_CYC);

    // Emulator command that restarts the watchdog
    localparam logic [7:0] EMU_CMD_DOG_RESTART = 8'h14;

    // Program start address after a watchdog restart
    localparam logic [15:0] START_ADDRESS = 16'h0000;

    // Reset values
    localparam logic [15:0] DOG_COUNT_RST = 16'h0000;
    localparam logic [12:0] DELAY_COUNT_RST = 13'h0000;
    localparam logic [11:0] GAP_COUNT_RST = 12'h000;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PULSE,
        ST_DELAY,
        ST_OSC_WAIT
    } dog_state_t;

endpackage

`default_nettype wire

// file: design/reset_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Reset on low reset pin, low emulator pin, low supply, crystal fault or overflow.
// - Low reset pin halts digital logic; crystal and clock keep running.
// - Low reset pin clears all configuration storage.
// - Low supply halts digital logic and clears configuration storage.
// - Watchdog counts crystal cycles; firmware refreshes within 1.5 s or processor resets.
// - Overflow resets processor; reset pulse is half a crystal period, and cpu_reset stays high through the restart delay.
// - After overflow reset, wait 4100 crystal cycles, then start at address 00.
// - Overflow sets the battery-held overflow flag, readable by the processor.
// - Low reset pin clears the overflow flag.
// - Stopped or slow crystal sets flag and holds cpu_reset; reset pulse and restart delay follow when crystal resumes.
// - Nothing reachable by firmware disables watchdog or oscillator.
// - Writing one to the refresh bit restarts the count.
// - Count also restarts while wake is zero or on emulator command 0x14.
module reset_and_watchdog
    import reset_watchdog_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        emu_reset_pin_n,
    input  wire logic        supply_below_bias,
    input  wire logic        slow_crystal_clock,
    input  wire logic        wake_state,
    input  wire logic        dog_refresh_bit,
    input  wire logic        emu_cmd_valid,
    input  wire logic [7:0]  emu_cmd,
    input  wire logic        flag_clear,
    output var  logic        digital_halt,
    output var  logic        config_clear,
    output var  logic        cpu_reset,
    output var  logic        cpu_start,
    output var  logic [15:0] cpu_start_address,
    output var  logic        dog_overflow_flag
);
    import reset_watchdog_pkg::*;

    logic [3:0]  sync1_reg;
    logic [3:0]  sync2_reg;
    logic        xtal_last_reg;
    logic        ext_low;
    logic        emu_low;
    logic        supply_low;
    logic        xtal_now;
    logic        rise_tick;
    logic        fall_tick;
    logic        halt_now;
    logic        dog_restart;
    logic        overflow_evt;
    logic        osc_fault_evt;
    logic        delay_done;
    dog_state_t  state_reg;
    dog_state_t  state_next;
    logic [15:0] dog_count_reg;
    logic [12:0] delay_count_reg;
    logic [11:0] gap_count_reg;
    logic        digital_halt_reg;
    logic        config_clear_reg;
    logic        cpu_reset_reg;
    logic        cpu_start_reg;
    logic        flag_reg;

    // Two-stage synchronisers for all pin inputs
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= {slow_crystal_clock, supply_below_bias, emu_reset_pin_n, ext_reset_pin_n};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            xtal_last_reg <= 1'b0;
        else
            xtal_last_reg <= xtal_now;
    end

    assign ext_low    = ~sync2_reg[0];
    assign emu_low    = ~sync2_reg[1];
    assign supply_low = sync2_reg[2];
    assign xtal_now   = sync2_reg[3];
    assign rise_tick  = xtal_now & ~xtal_last_reg;
    assign fall_tick  = ~xtal_now & xtal_last_reg;
    assign halt_now   = ext_low | emu_low | supply_low;

    // Refresh is a strobe: nothing stores it, so it reads as zero
    assign dog_restart = dog_refresh_bit
                       | ~wake_state
                       | (emu_cmd_valid & (emu_cmd == EMU_CMD_DOG_RESTART))
                       | halt_now
                       | (state_reg != ST_RUN);
    assign overflow_evt = (state_reg == ST_RUN) & rise_tick & (dog_count_reg == DOG_LAST)
                        & ~dog_restart;
    assign osc_fault_evt = (gap_count_reg == XTAL_GAP_LIMIT) & (state_reg != ST_OSC_WAIT);
    assign delay_done = (state_reg == ST_DELAY) & rise_tick & (delay_count_reg == RESTART_LAST);

    // Watchdog count in crystal cycles; no enable exists to stop it
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            dog_count_reg <= DOG_COUNT_RST;
        else if (dog_restart)
            dog_count_reg <= DOG_COUNT_RST;
        else if (rise_tick)
            dog_count_reg <= (dog_count_reg == DOG_LAST) ? DOG_COUNT_RST : dog_count_reg + 16'h0001;
    end

    // Crystal gap monitor in system cycles
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            gap_count_reg <= GAP_COUNT_RST;
        else if (rise_tick | fall_tick)
            gap_count_reg <= GAP_COUNT_RST;
        else if (gap_count_reg != XTAL_GAP_LIMIT)
            gap_count_reg <= gap_count_reg + 12'h001;
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (osc_fault_evt)
                    state_next = ST_OSC_WAIT;
                else if (overflow_evt)
                    state_next = ST_PULSE;
            end
            ST_PULSE:
            begin
                if (fall_tick)
                    state_next = ST_DELAY;
            end
            ST_DELAY:
            begin
                if (delay_done)
                    state_next = ST_RUN;
            end
            ST_OSC_WAIT:
            begin
                if (rise_tick)
                    state_next = ST_PULSE;
            end
            default:
                state_next = ST_RUN;
        endcase
        if (halt_now)
            state_next = ST_RUN;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            delay_count_reg <= DELAY_COUNT_RST;
        else if (state_reg != ST_DELAY)
            delay_count_reg <= DELAY_COUNT_RST;
        else if (rise_tick)
            delay_count_reg <= delay_count_reg + 13'h0001;
    end

    // Reset outputs
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            digital_halt_reg <= 1'b1;
            config_clear_reg <= 1'b1;
            cpu_reset_reg    <= 1'b1;
            cpu_start_reg    <= 1'b0;
        end
        else
        begin
            digital_halt_reg <= halt_now;
            config_clear_reg <= ext_low | supply_low;
            cpu_reset_reg    <= halt_now | (state_next != ST_RUN);
            cpu_start_reg    <= delay_done & ~halt_now;
        end
    end

    // Battery-held overflow flag; a set beats a clear in the same cycle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            flag_reg <= 1'b0;
        else if (overflow_evt | osc_fault_evt)
            flag_reg <= 1'b1;
        else if (flag_clear | ext_low)
            flag_reg <= 1'b0;
    end

    assign digital_halt      = digital_halt_reg;
    assign config_clear      = config_clear_reg;
    assign cpu_reset         = cpu_reset_reg;
    assign cpu_start         = cpu_start_reg;
    assign cpu_start_address = START_ADDRESS;
    assign dog_overflow_flag = flag_reg;

    property p_halt_sources;
        @(posedge clock) disable iff (sys_rst)
        (ext_low | emu_low | supply_low) |=> digital_halt_reg && cpu_reset_reg;
    endproperty
    a_halt_sources: assert property (p_halt_sources) else $error("halt not raised");

    property p_config_clear;
        @(posedge clock) disable iff (sys_rst)
        (ext_low | supply_low) |=> config_clear_reg;
    endproperty
    a_config_clear: assert property (p_config_clear) else $error("config not cleared");

    property p_overflow_pulse;
        @(posedge clock) disable iff (sys_rst)
        overflow_evt && !halt_now && !osc_fault_evt |=> state_reg == ST_PULSE && cpu_reset_reg;
    endproperty
    a_overflow_pulse: assert property (p_overflow_pulse) else $error("no reset on overflow");

    property p_flag_set;
        @(posedge clock) disable iff (sys_rst)
        (overflow_evt | osc_fault_evt) |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_ext_clear;
        @(posedge clock) disable iff (sys_rst)
        ext_low && !overflow_evt && !osc_fault_evt |=> !flag_reg;
    endproperty
    a_flag_ext_clear: assert property (p_flag_ext_clear) else $error("flag kept");

    property p_refresh_restart;
        @(posedge clock) disable iff (sys_rst)
        dog_refresh_bit |=> dog_count_reg == DOG_COUNT_RST;
    endproperty
    a_refresh_restart: assert property (p_refresh_restart) else $error("refresh ignored");

    property p_wake_cmd_restart;
        @(posedge clock) disable iff (sys_rst)
        !wake_state || (emu_cmd_valid && emu_cmd == EMU_CMD_DOG_RESTART)
        |=> dog_count_reg == DOG_COUNT_RST;
    endproperty
    a_wake_cmd_restart: assert property (p_wake_cmd_restart) else $error("restart missed");

    property p_delay_start;
        @(posedge clock) disable iff (sys_rst)
        delay_done && !halt_now |=> cpu_start_reg && !cpu_reset_reg && state_reg == ST_RUN;
    endproperty
    a_delay_start: assert property (p_delay_start) else $error("start not issued");

    property p_pulse_ends_on_fall;
        @(posedge clock) disable iff (sys_rst)
        state_reg == ST_PULSE && fall_tick && !halt_now |=> state_reg == ST_DELAY;
    endproperty
    a_pulse_ends_on_fall: assert property (p_pulse_ends_on_fall) else $error("pulse length");

    property p_osc_wait;
        @(posedge clock) disable iff (sys_rst)
        osc_fault_evt && state_reg == ST_RUN && !halt_now |=> state_reg == ST_OSC_WAIT && flag_reg;
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("crystal fault missed");

    c_overflow: cover property (@(posedge clock) disable iff (sys_rst) overflow_evt);
    c_start: cover property (@(posedge clock) disable iff (sys_rst) cpu_start_reg);
    c_osc_fault: cover property (@(posedge clock) disable iff (sys_rst) osc_fault_evt);
    c_ext_reset: cover property (@(posedge clock) disable iff (sys_rst) ext_low ##1 !ext_low);

endmodule

`default_nettype wire

// file: testbench/meter_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module meter_cpu_model
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic xtal_run,
    input  wire logic refresh_en,
    input  wire logic fw_clear_en,
    input  wire logic cpu_start,
    input  wire logic dog_overflow_flag,
    output var  logic slow_crystal_clock,
    output var  logic dog_refresh_bit,
    output var  logic flag_clear,
    output var  logic flag_seen
);
    logic [8:0] gap_reg;
    logic       boot_reg;

    // Crystal sped up to keep the run short
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            slow_crystal_clock <= 1'h0;
        else if (xtal_run)
            slow_crystal_clock <= ~slow_crystal_clock;

    // Refresh every 512 cycles, far inside the limit
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
        begin
            gap_reg         <= 9'h000;
            dog_refresh_bit <= 1'h0;
        end
        else
        begin
            gap_reg         <= gap_reg + 9'h001;
            dog_refresh_bit <= refresh_en && gap_reg == 9'h000;
        end

    // Startup: read flag, then clear it
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
        begin
            boot_reg   <= 1'h0;
            flag_clear <= 1'h0;
            flag_seen  <= 1'h0;
        end
        else
        begin
            boot_reg   <= cpu_start;
            flag_clear <= boot_reg && fw_clear_en;
            if (boot_reg)
                flag_seen <= dog_overflow_flag;
        end
endmodule

`default_nettype wire

// file: testbench/reset_and_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_and_watchdog_tb;
    import reset_watchdog_pkg::*;
    logic        clock = 1'h0;
    logic        sys_rst = 1'h1;
    logic        ext_reset_pin_n = 1'h1;
    logic        emu_reset_pin_n = 1'h1;
    logic        supply_below_bias = 1'h0;
    logic        wake_state = 1'h0;
    logic        emu_cmd_valid = 1'h0;
    logic [7:0]  emu_cmd = 8'h00;
    logic        xtal_run = 1'h1;
    logic        refresh_en = 1'h0;
    logic        fw_clear_en = 1'h1;
    logic        slow_crystal_clock, dog_refresh_bit, flag_clear, flag_seen;
    logic        digital_halt, config_clear, cpu_reset, cpu_start, dog_overflow_flag;
    logic [15:0] cpu_start_address;
    int          fail_count = 0, compares = 0, cyc = 0, last_ref = 0, n;

    always #4 clock = ~clock;

    // Cycle of the latest watchdog restart request
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (dog_refresh_bit || (emu_cmd_valid && emu_cmd == EMU_CMD_DOG_RESTART))
            last_ref <= cyc;
    end

    reset_and_watchdog u_reset_and_watchdog (.clock(clock), .sys_rst(sys_rst),
        .ext_reset_pin_n(ext_reset_pin_n), .emu_reset_pin_n(emu_reset_pin_n),
        .supply_below_bias(supply_below_bias), .slow_crystal_clock(slow_crystal_clock),
        .wake_state(wake_state), .dog_refresh_bit(dog_refresh_bit),
        .emu_cmd_valid(emu_cmd_valid), .emu_cmd(emu_cmd), .flag_clear(flag_clear),
        .digital_halt(digital_halt), .config_clear(config_clear), .cpu_reset(cpu_reset),
        .cpu_start(cpu_start), .cpu_start_address(cpu_start_address),
        .dog_overflow_flag(dog_overflow_flag));

    meter_cpu_model u_meter_cpu_model (.clock(clock), .sys_rst(sys_rst),
        .xtal_run(xtal_run), .refresh_en(refresh_en), .fw_clear_en(fw_clear_en),
        .cpu_start(cpu_start), .dog_overflow_flag(dog_overflow_flag),
        .slow_crystal_clock(slow_crystal_clock), .dog_refresh_bit(dog_refresh_bit),
        .flag_clear(flag_clear), .flag_seen(flag_seen));

    task final_report;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task check_bit(input logic a, input logic e);
        compares++;
        if (a !== e)
        begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task check_word(input logic [15:0] a, input logic [15:0] e);
        compares++;
        if (a !== e)
        begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task check_count(input int a, input int lo, input int hi);
        compares++;
        if (a < lo || a > hi)
        begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h..%h", $time, a, lo, hi);
        end
    endtask

    task cycles(input int k);
        repeat (k) @(posedge clock);
    endtask

    // Bounded wait for cpu_reset (0) or cpu_start (1) high
    task automatic wait_out(input bit pick, input int max);
        n = 0;
        while (((pick ? cpu_start : cpu_reset) !== 1'h1) && n < max)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if ((pick ? cpu_start : cpu_reset) !== 1'h1)
        begin
            fail_count++;
            $display("BAD t=%0t wait %h lim %h", $time, n, max);
            final_report;
        end
    endtask

    task send_cmd(input logic [7:0] c);
        @(posedge clock);
        emu_cmd       <= c;
        emu_cmd_valid <= 1'h1;
        @(posedge clock);
        emu_cmd_valid <= 1'h0;
    endtask

    task test_pins;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            ext_reset_pin_n   <= i != 0;
            emu_reset_pin_n   <= i != 1;
            supply_below_bias <= i == 2;
            cycles(5);
            #1;
            check_bit(digital_halt, 1'h1);
            check_bit(config_clear, i != 1);
            check_bit(cpu_reset, 1'h1);
            @(posedge clock);
            ext_reset_pin_n   <= 1'h1;
            emu_reset_pin_n   <= 1'h1;
            supply_below_bias <= 1'h0;
            cycles(5);
            #1;
            check_bit(digital_halt, 1'h0);
            check_bit(config_clear, 1'h0);
        end
        check_word(cpu_start_address, START_ADDRESS);
        $display("test_pins done");
    endtask

    task test_overflow;
        @(posedge clock);
        wake_state <= 1'h1;
        refresh_en <= 1'h1;
        cycles(600);
        refresh_en <= 1'h0;
        cycles(600);
        send_cmd(EMU_CMD_DOG_RESTART);
        cycles(600);
        send_cmd(8'h15);
        wait_out(0, 100000);
        check_count(cyc - last_ref, 98296, 98312);
        check_bit(dog_overflow_flag, 1'h1);
        wait_out(1, 9000);
        check_count(n, 8196, 8212);
        check_bit(cpu_reset, 1'h0);
        cycles(3);
        #1;
        check_bit(flag_seen, 1'h1);
        check_bit(dog_overflow_flag, 1'h0);
        $display("test_overflow done");
    endtask

    task test_fault;
        @(posedge clock);
        fw_clear_en <= 1'h0;
        xtal_run    <= 1'h0;
        cycles(4000);
        #1;
        check_bit(dog_overflow_flag, 1'h1);
        check_bit(cpu_reset, 1'h1);
        @(posedge clock);
        xtal_run <= 1'h1;
        wait_out(1, 9000);
        check_count(n, 8196, 8216);
        check_bit(dog_overflow_flag, 1'h1);
        cycles(3);
        #1;
        check_bit(flag_seen, 1'h1);
        @(posedge clock);
        ext_reset_pin_n <= 1'h0;
        cycles(5);
        #1;
        check_bit(dog_overflow_flag, 1'h0);
        @(posedge clock);
        ext_reset_pin_n <= 1'h1;
        $display("test_fault done");
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'h0;
        cycles(6);
        test_pins;
        test_overflow;
        test_fault;
        final_report;
    end
endmodule

`default_nettype wire
